//--- common/tec_pkg.sv
// tec_pkg: constants and carrier types for the 16-bit timer/event counter.
// assumes one system clock; register port is address/strobe/read-data.
package tec_pkg;

   // register indices (byte address = index * 4)
   localparam logic [7:0] TEC_IDX_COUNT = 8'h00;
   localparam logic [7:0] TEC_IDX_CCA = 8'h01;
   localparam logic [7:0] TEC_IDX_CCB = 8'h02;
   localparam logic [7:0] TEC_IDX_MODE = 8'h03;
   localparam logic [7:0] TEC_IDX_CCCTL = 8'h04;
   localparam logic [7:0] TEC_IDX_PRESC = 8'h05;
   localparam logic [7:0] TEC_IDX_OUTCTL = 8'h06;
   localparam int TEC_ADDR_W = 10;
   localparam logic [TEC_ADDR_W-1:0] TEC_ADDR_COUNT = 10'h000;
   localparam logic [TEC_ADDR_W-1:0] TEC_ADDR_CCA = 10'h004;
   localparam logic [TEC_ADDR_W-1:0] TEC_ADDR_CCB = 10'h008;
   localparam logic [TEC_ADDR_W-1:0] TEC_ADDR_MODE = 10'h00c;
   localparam logic [TEC_ADDR_W-1:0] TEC_ADDR_CCCTL = 10'h010;
   localparam logic [TEC_ADDR_W-1:0] TEC_ADDR_PRESC = 10'h014;
   localparam logic [TEC_ADDR_W-1:0] TEC_ADDR_OUTCTL = 10'h018;

   // timer_mode_control fields
   localparam int TEC_MODE_OVF_BIT = 0;
   localparam int TEC_MODE_RUN_LO = 2;
   localparam int TEC_MODE_RUN_HI = 3;
   // capcmp_control fields
   localparam int TEC_CC_A_CAP_BIT = 0;
   localparam int TEC_CC_A_SRC_BIT = 1;
   localparam int TEC_CC_B_CAP_BIT = 2;
   // prescaler_mode_reg fields
   localparam int TEC_PR_CLK_LO = 0;
   localparam int TEC_PR_CLK_HI = 1;
   localparam int TEC_PR_EDGE_A_LO = 4;
   localparam int TEC_PR_EDGE_A_HI = 5;
   localparam int TEC_PR_EDGE_B_LO = 6;
   localparam int TEC_PR_EDGE_B_HI = 7;
   // output_control_reg fields
   localparam int TEC_OC_ONESHOT_EN = 0;
   localparam int TEC_OC_ONESHOT_TRIG = 1;

   localparam logic [15:0] TEC_CNT_RST = 16'h0000;
   localparam logic [15:0] TEC_CNT_MAX = 16'hffff;
   localparam logic [7:0] TEC_REG8_RST = 8'h00;
   localparam logic [3:0] TEC_DIV_RST = 4'h0;

   typedef enum logic [1:0] {
      TEC_RUN_STOP,
      TEC_RUN_FREE,
      TEC_RUN_CLR_EDGE,
      TEC_RUN_CLR_MATCH
   } tec_run_t;

   // edge select: 00 falling, 01 rising, 10 none, 11 both
   typedef enum logic [1:0] {
      TEC_EDGE_FALL,
      TEC_EDGE_RISE,
      TEC_EDGE_NONE,
      TEC_EDGE_BOTH
   } tec_edge_t;

   typedef struct packed {
      logic [TEC_ADDR_W-1:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } tec_bus_req_t;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] cca;
      logic [15:0] ccb;
      tec_run_t run;
      logic ovf;
      logic [2:0] ccctl;
      logic [7:0] presc;
      logic oneshot_en;
      logic [3:0] div;
      logic [1:0] ina_sync;
      logic [1:0] inb_sync;
      logic ina_prev;
      logic inb_prev;
      logic [15:0] rdata;
      logic irq_a;
      logic irq_b;
   } tec_state_t;

endpackage : tec_pkg

//--- hw/tec_timer.sv
// tec_timer: one channel of a 16-bit timer/event counter with two
// capture/compare registers and a small register port.
// assumes pins timer_input_a/b are asynchronous; all else on clk_sys_i.
`timescale 1ns/1ps

// Function
// - 16-bit counter advances on selected count clock
// - counter reads zero while stopped
// - counter cleared on reset or stop
// - edge mode clears counter on input A
// - match mode clears counter on register A
// - one-shot clears on trigger or input A
// - two 16-bit capture/compare registers, reset zero
// - compare A raises match A as a one-cycle pulse
// - capture A on opposite A edge or B
// - compare B raises match B on equality
// - capture B on valid input A edge
// - no capture while stopped; register keeps its value
// - captured value kept until next capture, write or reset
// - run-mode encoding stop/free/edge/match
// - overflow flag on wrap, cleared by software/stop
module tec_timer (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // register port
   input wire tec_pkg::tec_bus_req_t bus_i,
   output logic [15:0] rdata_o,
   // timer pins
   input wire logic timer_input_a_i,
   input wire logic timer_input_b_i,
   // events and status
   output logic match_irq_a_o,
   output logic match_irq_b_o,
   output logic overflow_flag_o
);
   import tec_pkg::*;

   tec_state_t s_r;
   tec_state_t s_nxt;

   logic running;
   logic tick;
   logic ina;
   logic inb;
   logic a_rise;
   logic a_fall;
   logic b_rise;
   logic b_fall;
   logic a_valid;
   logic a_opp;
   logic b_valid;
   logic cap_a;
   logic cap_b;
   logic match_a;
   logic match_b;
   logic clr;
   logic wrap;
   logic os_trig;
   logic wr_mode;
   logic [15:0] cnt_inc;

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic rise,
                                     input logic fall);
      unique case (tec_edge_t'(sel))
         TEC_EDGE_FALL: edge_hit = fall;
         TEC_EDGE_RISE: edge_hit = rise;
         TEC_EDGE_NONE: edge_hit = 1'b0;
         TEC_EDGE_BOTH: edge_hit = rise | fall;
      endcase
   endfunction : edge_hit

   always_comb begin
      s_nxt = s_r;
      running = (s_r.run != TEC_RUN_STOP);
      // second synchroniser stage only feeds edge logic
      ina = s_r.ina_sync[1];
      inb = s_r.inb_sync[1];
      a_rise = ina & ~s_r.ina_prev;
      a_fall = ~ina & s_r.ina_prev;
      b_rise = inb & ~s_r.inb_prev;
      b_fall = ~inb & s_r.inb_prev;
      a_valid = running & edge_hit(
         s_r.presc[TEC_PR_EDGE_A_HI:TEC_PR_EDGE_A_LO], a_rise, a_fall);
      a_opp = running & edge_hit(
         s_r.presc[TEC_PR_EDGE_A_HI:TEC_PR_EDGE_A_LO], a_fall, a_rise);
      b_valid = running & edge_hit(
         s_r.presc[TEC_PR_EDGE_B_HI:TEC_PR_EDGE_B_LO], b_rise, b_fall);

      // count clock: sys/1, /2, /4 or /8
      unique case (s_r.presc[TEC_PR_CLK_HI:TEC_PR_CLK_LO])
         2'b00: tick = running;
         2'b01: tick = running & s_r.div[0];
         2'b10: tick = running & (&s_r.div[1:0]);
         2'b11: tick = running & (&s_r.div[2:0]);
      endcase

      // equality is tested on the tick so one event gives one pulse
      match_a = tick & ~s_r.ccctl[TEC_CC_A_CAP_BIT]
                & (s_r.count == s_r.cca);
      match_b = tick & ~s_r.ccctl[TEC_CC_B_CAP_BIT]
                & (s_r.count == s_r.ccb);

      cap_a = s_r.ccctl[TEC_CC_A_CAP_BIT] &
              (s_r.ccctl[TEC_CC_A_SRC_BIT] ? a_opp : b_valid);
      // captures need a running timer; a same-cycle stop still captures
      cap_b = s_r.ccctl[TEC_CC_B_CAP_BIT] & a_valid;

      wr_mode = bus_i.wr & (bus_i.addr == TEC_ADDR_MODE);
      os_trig = bus_i.wr & (bus_i.addr == TEC_ADDR_OUTCTL) &
                bus_i.wdata[TEC_OC_ONESHOT_TRIG] & s_r.oneshot_en;

      clr = 1'b0;
      if (s_r.oneshot_en & running & (os_trig | a_valid)) begin
         clr = 1'b1;
      end
      if ((s_r.run == TEC_RUN_CLR_EDGE) & a_valid) begin
         clr = 1'b1;
      end
      if ((s_r.run == TEC_RUN_CLR_MATCH) & match_a) begin
         clr = 1'b1;
      end
      wrap = tick & ~clr & (s_r.count == TEC_CNT_MAX);
      cnt_inc = s_r.count + 16'h0001;

      if (!running) begin
         s_nxt.count = TEC_CNT_RST;
      end else if (clr) begin
         s_nxt.count = TEC_CNT_RST;
      end else if (tick) begin
         s_nxt.count = cnt_inc;
      end

      // register writes; captures win over a write in the same cycle
      if (bus_i.wr) begin
         unique case (bus_i.addr)
            TEC_ADDR_CCA: s_nxt.cca = bus_i.wdata;
            TEC_ADDR_CCB: s_nxt.ccb = bus_i.wdata;
            TEC_ADDR_CCCTL: s_nxt.ccctl = bus_i.wdata[2:0];
            TEC_ADDR_PRESC: s_nxt.presc = bus_i.wdata[7:0];
            TEC_ADDR_OUTCTL:
               s_nxt.oneshot_en = bus_i.wdata[TEC_OC_ONESHOT_EN];
            default: ;
         endcase
      end
      if (wr_mode) begin
         s_nxt.run = tec_run_t'(
            bus_i.wdata[TEC_MODE_RUN_HI:TEC_MODE_RUN_LO]);
         s_nxt.ovf = bus_i.wdata[TEC_MODE_OVF_BIT];
      end
      if (cap_a) begin
         s_nxt.cca = s_r.count;
      end
      if (cap_b) begin
         s_nxt.ccb = s_r.count;
      end
      // stop clears flag; wrap sets it and wins over a clear
      if (wr_mode && bus_i.wdata[TEC_MODE_RUN_HI:TEC_MODE_RUN_LO] == 2'b00)
      begin
         s_nxt.ovf = 1'b0;
      end
      if (wrap) begin
         s_nxt.ovf = 1'b1;
      end

      s_nxt.div = running ? s_r.div + 4'h1 : TEC_DIV_RST;
      s_nxt.ina_sync = {s_r.ina_sync[0], timer_input_a_i};
      s_nxt.inb_sync = {s_r.inb_sync[0], timer_input_b_i};
      s_nxt.ina_prev = ina;
      s_nxt.inb_prev = inb;
      s_nxt.irq_a = match_a;
      s_nxt.irq_b = match_b;

      s_nxt.rdata = 16'h0000;
      if (bus_i.rd) begin
         unique case (bus_i.addr)
            TEC_ADDR_COUNT:
               s_nxt.rdata = running ? s_r.count : TEC_CNT_RST;
            TEC_ADDR_CCA: s_nxt.rdata = s_r.cca;
            TEC_ADDR_CCB: s_nxt.rdata = s_r.ccb;
            TEC_ADDR_MODE: s_nxt.rdata = {12'h000, s_r.run, 1'b0, s_r.ovf};
            TEC_ADDR_CCCTL: s_nxt.rdata = {13'h0000, s_r.ccctl};
            TEC_ADDR_PRESC: s_nxt.rdata = {8'h00, s_r.presc};
            TEC_ADDR_OUTCTL: s_nxt.rdata = {15'h0000, s_r.oneshot_en};
            default: s_nxt.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata_o = s_r.rdata;
   assign match_irq_a_o = s_r.irq_a;
   assign match_irq_b_o = s_r.irq_b;
   assign overflow_flag_o = s_r.ovf;

endmodule : tec_timer

//--- test/tec_timer_asserts.sv
// tec_timer_asserts: port-level checks for the timer channel.
// assumes binding onto tec_timer; sees only its ports.
`timescale 1ns/1ps
module tec_timer_asserts (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // register port
   input wire tec_pkg::tec_bus_req_t bus_i,
   input wire logic [15:0] rdata_o,
   // pins and events
   input wire logic timer_input_a_i,
   input wire logic timer_input_b_i,
   input wire logic match_irq_a_o,
   input wire logic match_irq_b_o,
   input wire logic overflow_flag_o
);
   import tec_pkg::*;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   // run mode as last written by software
   logic [1:0] run_r;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) run_r <= 2'b00;
      else if (bus_i.wr && bus_i.addr == TEC_ADDR_MODE) begin
         run_r <= bus_i.wdata[3:2];
      end
   end
   a_rdata_idle: assert property (rdata_o != 16'h0000 |-> $past(bus_i.rd))
      else $error("read data outside read slot");
   a_irq_a_pulse: assert property (match_irq_a_o |=> !match_irq_a_o)
      else $error("match a held");
   a_irq_b_pulse: assert property (match_irq_b_o |=> !match_irq_b_o)
      else $error("match b held");
   a_stop_reads_zero: assert property (bus_i.rd &&
      bus_i.addr == TEC_ADDR_COUNT && run_r == 2'b00 |=> rdata_o == 16'h0000)
      else $error("stopped count not zero");
   a_unmapped_zero: assert property (bus_i.rd &&
      bus_i.addr > TEC_ADDR_OUTCTL |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_cca_readback: assert property (run_r == 2'b00 && bus_i.wr &&
      bus_i.addr == TEC_ADDR_CCA ##2 bus_i.rd && bus_i.addr == TEC_ADDR_CCA
      |=> rdata_o == $past(bus_i.wdata, 3))
      else $error("register a readback");
   a_stopped_quiet: assert property (run_r == 2'b00 &&
      $past(run_r) == 2'b00 && $past(run_r, 2) == 2'b00
      |-> !match_irq_a_o && !match_irq_b_o)
      else $error("event while stopped");
   a_stop_clears_ovf: assert property (bus_i.wr &&
      bus_i.addr == TEC_ADDR_MODE && bus_i.wdata[3:0] == 4'h0
      |=> !overflow_flag_o)
      else $error("overflow kept after stop");
endmodule : tec_timer_asserts
bind tec_timer tec_timer_asserts i_asserts (.clk_sys_i(clk_sys_i),
   .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .timer_input_a_i(timer_input_a_i), .timer_input_b_i(timer_input_b_i),
   .match_irq_a_o(match_irq_a_o), .match_irq_b_o(match_irq_b_o),
   .overflow_flag_o(overflow_flag_o));

//--- test/tec_pins_model.sv
// tec_pins_model: pulse sources on the two timer input pins.
// assumes one-cycle fire requests; pins idle low.
`timescale 1ns/1ps
module tec_pins_model (
   // clock
   input wire logic clk_sys_i,
   // pulse requests, bit 0 pin a
   input wire logic [1:0] fire_i,
   // pin levels
   output logic [1:0] pins_o
);
   logic [2:0] hold_r [2] = '{3'h0, 3'h0};
   // four-cycle pulse, wide enough for the input synchroniser
   always @(posedge clk_sys_i) begin
      for (int i = 0; i < 2; i++) begin
         if (fire_i[i]) hold_r[i] <= 3'h4;
         else if (hold_r[i] != 3'h0) hold_r[i] <= hold_r[i] - 3'h1;
      end
   end
   always_comb pins_o = {hold_r[1] != 3'h0, hold_r[0] != 3'h0};
endmodule : tec_pins_model

//--- test/tb.sv
// tb: self-checking bench for tec_timer.
// assumes tec_pins_model drives the pins; reads checked from a queue.
`timescale 1ns/1ps
module tb;
   import tec_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   tec_bus_req_t bus = '0;
   logic [15:0] rdata;
   logic pin_a, pin_b, irq_a, irq_b, ovf, rd_d = 1'b0;
   logic [1:0] fire = 2'b00;
   logic [15:0] q[$];
   logic [15:0] rv;
   int n_fail = 0, n_checks = 0, n_irq = 0, cyc = 0, last = 0, gap = 0, n;
   int seed = 32'hbdb723a4;
   initial forever #20 clk_sys_i = ~clk_sys_i;
   tec_timer i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus_i(bus),
      .rdata_o(rdata), .timer_input_a_i(pin_a), .timer_input_b_i(pin_b),
      .match_irq_a_o(irq_a), .match_irq_b_o(irq_b), .overflow_flag_o(ovf));
   tec_pins_model i_pins (.clk_sys_i(clk_sys_i), .fire_i(fire),
      .pins_o({pin_b, pin_a}));
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk
   task automatic acc(input logic w, input logic [9:0] a,
                      input logic [15:0] d);
      @(posedge clk_sys_i);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk_sys_i);
      bus <= '0;
   endtask : acc
   task automatic rd(input logic [9:0] a, input logic [15:0] e);
      q.push_back(e);
      acc(1'b0, a, 16'h0000);
   endtask : rd
   task automatic pulse(input int i);
      @(posedge clk_sys_i);
      fire[i] <= 1'b1;
      @(posedge clk_sys_i);
      fire[i] <= 1'b0;
   endtask : pulse
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   // watcher: read data one cycle after the strobe, match spacing
   always @(posedge clk_sys_i) begin
      cyc++;
      if (rd_d) chk("rdata", q.pop_front(), {16'h0000, rdata});
      rd_d = bus.rd;
      if (irq_a) begin
         n_irq++;
         chk("irq_b", 1, irq_b);
         if (gap != 0 && last != 0) chk("gap", gap, cyc - last);
         last = cyc;
      end
      if (cyc == 90000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      repeat (4) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      for (int a = 0; a < 8; a++) rd(10'(a * 4), 16'h0000);
      rv = 16'($random(seed));
      acc(1'b1, TEC_ADDR_CCA, rv);
      rd(TEC_ADDR_CCA, rv);
      n = 3 + ($random(seed) & 15);
      acc(1'b1, TEC_ADDR_CCA, 16'(n));
      acc(1'b1, TEC_ADDR_CCB, 16'(n));
      for (int d = 0; d < 4; d++) begin
         acc(1'b1, TEC_ADDR_PRESC, 16'(d));
         gap = (n + 1) << d;
         last = 0;
         acc(1'b1, TEC_ADDR_MODE, 16'h000c);
         repeat (5 * gap) @(posedge clk_sys_i);
         acc(1'b1, TEC_ADDR_MODE, 16'h0000);
      end
      chk("irq_count", 1, n_irq >= 12);
      gap = 0;
      // rising edges valid on both pins, clock undivided
      acc(1'b1, TEC_ADDR_PRESC, 16'h0050);
      acc(1'b1, TEC_ADDR_CCCTL, 16'h0005);
      acc(1'b1, TEC_ADDR_MODE, 16'h0008);
      pulse(0);
      repeat (8) @(posedge clk_sys_i);
      pulse(1);
      repeat (8) @(posedge clk_sys_i);
      pulse(0);
      repeat (8) @(posedge clk_sys_i);
      acc(1'b1, TEC_ADDR_MODE, 16'h0000);
      rd(TEC_ADDR_CCA, 16'h0009);
      rd(TEC_ADDR_CCB, 16'h0013);
      // register a captures on the falling (opposite) edge of pin a
      acc(1'b1, TEC_ADDR_CCCTL, 16'h0003);
      acc(1'b1, TEC_ADDR_MODE, 16'h0004);
      pulse(0);
      repeat (66000) @(posedge clk_sys_i);
      chk("ovf", 1, ovf);
      rd(TEC_ADDR_MODE, 16'h0005);
      acc(1'b1, TEC_ADDR_MODE, 16'h0004);
      rd(TEC_ADDR_MODE, 16'h0004);
      chk("ovf", 0, ovf);
      // one-shot trigger clears the running count
      acc(1'b1, TEC_ADDR_OUTCTL, 16'h0001);
      acc(1'b1, TEC_ADDR_OUTCTL, 16'h0003);
      rd(TEC_ADDR_COUNT, 16'h0001);
      acc(1'b1, TEC_ADDR_MODE, 16'h0000);
      rd(TEC_ADDR_COUNT, 16'h0000);
      rd(TEC_ADDR_MODE, 16'h0000);
      rd(TEC_ADDR_CCA, 16'h0008);
      repeat (2) @(posedge clk_sys_i);
      test_done();
   end
endmodule : tb
